// file: logic/pmea_cfg.svh
// constants of the program/verify mode block: map, reset values, command codes
// assumes inclusion by bare name from the package and the design file
`ifndef PMEA_CFG_SVH
`define PMEA_CFG_SVH

// ----------------------------------------
// address map
// ----------------------------------------
`define PMEA_ADDR_W 14
`define PMEA_WORD_W 14
`define PMEA_USER_BASE 14'h0000
`define PMEA_USER_TOP 14'h1fff
`define PMEA_CFG_BASE 14'h2000
`define PMEA_CFG_TOP 14'h3fff
`define PMEA_CFG_WORDS 10
`define PMEA_IDX_W 4
`define PMEA_ID_LAST 4'h3
`define PMEA_IDX_ALT_FIRST 4'h6
`define PMEA_IDX_CONFIG 4'h7
`define PMEA_IDX_CAL0 4'h8
`define PMEA_IDX_CAL1 4'h9
`define PMEA_MAIN_LAST 4'h8
`define PMEA_ALT_LAST 4'h9

// ----------------------------------------
// reset values
// ----------------------------------------
`define PMEA_ERASED 14'h3fff
`define PMEA_CAL0_RST 14'h3fff
`define PMEA_CAL1_RST 14'h3fff

// ----------------------------------------
// serial framing and commands (low four code bits)
// ----------------------------------------
`define PMEA_CMD_BITS 5'd6
`define PMEA_DATA_BITS 5'd16
`define PMEA_CMD_LOAD_CFG 4'h0
`define PMEA_CMD_LOAD_PROG 4'h2
`define PMEA_CMD_LOAD_DATA 4'h3
`define PMEA_CMD_READ_PROG 4'h4
`define PMEA_CMD_READ_DATA 4'h5
`define PMEA_CMD_INCR 4'h6
`define PMEA_CMD_BEGIN 4'h8
`define PMEA_CMD_BULK_PROG 4'h9

// ----------------------------------------
// buffering
// ----------------------------------------
`define PMEA_FIFO_DEPTH 8

`endif

// file: logic/pmea_pkg.sv
// types of the program/verify mode block
// assumes pmea_cfg.svh is on the include path
`include "pmea_cfg.svh"

package pmea_pkg;

  // one word bound for the program array, address with data
  typedef struct packed {
    logic [`PMEA_ADDR_W-1:0] addr;
    logic [`PMEA_WORD_W-1:0] data;
  } pmea_wr_t;

  typedef enum logic [1:0] {
    PMEA_ST_CMD,
    PMEA_ST_DATA
  } pmea_state_t;

endpackage

// file: logic/pmea_prog_if.sv
// serial program/verify mode port: entry, address counter, configuration words
// assumes a single core_clk; programmer pins arrive asynchronously

`include "pmea_cfg.svh"

// ----------------------------------------
// buffer between serial side and program array
// ----------------------------------------
module pmea_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = `PMEA_FIFO_DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  assign in_ready = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rd_ptr_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + AW'(1);
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + AW'(1);
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ----------------------------------------
// top: program/verify mode interface
// ----------------------------------------
module pmea_prog_if (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // programmer pins
  input wire logic prog_clock_pin,
  input wire logic prog_data_pin_in,
  output logic prog_data_pin_out,
  output logic prog_data_pin_oe,
  input wire logic master_clear_hv,
  // device straps and state
  input wire logic alt_group_strap,
  input wire logic code_protect,
  // mode status towards the rest of the chip
  output logic prog_mode_active,
  output logic other_logic_reset,
  output logic port_a_bit_four_hiz,
  // program array access
  output logic [`PMEA_ADDR_W-1:0] array_rd_addr,
  input wire logic [`PMEA_WORD_W-1:0] array_rd_data,
  output logic array_wr_valid,
  input wire logic array_wr_ready,
  output pmea_pkg::pmea_wr_t array_wr_word,
  output logic array_erase
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] clk_sync_q;
  logic [1:0] dat_sync_q;
  logic [1:0] hv_sync_q;
  logic clk_rise;
  logic clk_fall;
  logic din;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_sync_q <= '0;
      dat_sync_q <= '0;
      hv_sync_q <= '0;
    end else begin
      clk_sync_q <= {clk_sync_q[1:0], prog_clock_pin};
      dat_sync_q <= {dat_sync_q[0], prog_data_pin_in};
      hv_sync_q <= {hv_sync_q[0], master_clear_hv};
    end
  end

  // edges taken from the second and third stages only
  assign clk_rise = clk_sync_q[1] && !clk_sync_q[2];
  assign clk_fall = !clk_sync_q[1] && clk_sync_q[2];
  assign din = dat_sync_q[1];

  // ----------------------------------------
  // strap capture after reset release
  // ----------------------------------------
  logic strap_done_q;
  logic alt_group_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_q <= 1'b0;
      alt_group_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      alt_group_q <= alt_group_strap;
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // top bit is held, so the config region can never fall back to user
  function automatic logic [`PMEA_ADDR_W-1:0] next_addr(input logic [`PMEA_ADDR_W-1:0] a);
    next_addr = {a[`PMEA_ADDR_W-1], a[`PMEA_ADDR_W-2:0] + 13'h0001};
  endfunction

  function automatic logic cfg_usable(input logic [`PMEA_ADDR_W-1:0] a, input logic alt);
    logic [`PMEA_ADDR_W-1:0] off;
    logic [`PMEA_IDX_W-1:0] idx;
    off = a - `PMEA_CFG_BASE;
    idx = off[`PMEA_IDX_W-1:0];
    if (off >= 14'(`PMEA_CFG_WORDS)) begin
      cfg_usable = 1'b0;
    end else if (idx <= `PMEA_ID_LAST) begin
      cfg_usable = 1'b1;
    end else if (alt) begin
      cfg_usable = (idx >= `PMEA_IDX_ALT_FIRST) && (idx <= `PMEA_ALT_LAST);
    end else begin
      cfg_usable = (idx == `PMEA_IDX_CONFIG) || (idx == `PMEA_MAIN_LAST);
    end
  endfunction

  // ----------------------------------------
  // mode tracking
  // ----------------------------------------
  logic mode_q;
  logic mode_entry;

  assign mode_entry = hv_sync_q[1] && !mode_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= 1'b0;
      other_logic_reset <= 1'b0;
      port_a_bit_four_hiz <= 1'b0;
    end else begin
      mode_q <= hv_sync_q[1];
      other_logic_reset <= hv_sync_q[1];
      port_a_bit_four_hiz <= hv_sync_q[1];
    end
  end

  assign prog_mode_active = mode_q;

  // ----------------------------------------
  // serial framing
  // ----------------------------------------
  pmea_pkg::pmea_state_t state_q;
  logic [4:0] bit_cnt_q;
  logic [5:0] cmd_q;
  logic [5:0] cmd_full;
  logic is_read_q;
  logic is_cfg_load_q;
  logic [`PMEA_WORD_W-1:0] rd_word_q;
  logic [`PMEA_WORD_W-1:0] shift_q;
  logic [`PMEA_WORD_W-1:0] latch_q;
  logic [`PMEA_ADDR_W-1:0] addr_q;
  logic cmd_done;
  logic data_done;
  logic [3:0] op;
  logic [`PMEA_WORD_W-1:0] read_value;
  logic [`PMEA_WORD_W-1:0] cfg_q [`PMEA_CFG_WORDS];
  logic [`PMEA_IDX_W-1:0] cfg_idx;
  logic in_cfg;

  assign cmd_full = {din, cmd_q[5:1]};
  assign op = cmd_full[3:0];
  assign cmd_done = mode_q && (state_q == pmea_pkg::PMEA_ST_CMD) && clk_fall
    && (bit_cnt_q == `PMEA_CMD_BITS - 5'd1);
  assign data_done = mode_q && (state_q == pmea_pkg::PMEA_ST_DATA) && clk_fall
    && (bit_cnt_q == `PMEA_DATA_BITS - 5'd1);
  assign in_cfg = addr_q[`PMEA_ADDR_W-1];
  assign cfg_idx = addr_q[`PMEA_IDX_W-1:0];

  // read source picked when the command completes
  always_comb begin
    read_value = '0;
    if (in_cfg) begin
      if (cfg_usable(addr_q, alt_group_q)) begin
        read_value = cfg_q[cfg_idx];
      end
    end else if (!code_protect) begin
      read_value = array_rd_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= pmea_pkg::PMEA_ST_CMD;
      bit_cnt_q <= '0;
      cmd_q <= '0;
      is_read_q <= 1'b0;
      is_cfg_load_q <= 1'b0;
      rd_word_q <= '0;
      shift_q <= '0;
    end else if (!mode_q || mode_entry) begin
      state_q <= pmea_pkg::PMEA_ST_CMD;
      bit_cnt_q <= '0;
      cmd_q <= '0;
      is_read_q <= 1'b0;
      is_cfg_load_q <= 1'b0;
    end else begin
      case (state_q)
        pmea_pkg::PMEA_ST_CMD: begin
          if (clk_fall) begin
            cmd_q <= cmd_full;
            bit_cnt_q <= cmd_done ? 5'd0 : bit_cnt_q + 5'd1;
            if (cmd_done) begin
              is_read_q <= (op == `PMEA_CMD_READ_PROG) || (op == `PMEA_CMD_READ_DATA);
              is_cfg_load_q <= (op == `PMEA_CMD_LOAD_CFG);
              rd_word_q <= (op == `PMEA_CMD_READ_PROG) ? read_value : '0;
              if (op <= `PMEA_CMD_READ_DATA && op != 4'h1) begin
                state_q <= pmea_pkg::PMEA_ST_DATA;
              end
            end
          end
        end
        pmea_pkg::PMEA_ST_DATA: begin
          if (clk_fall) begin
            // bits 1..14 carry the word; first and last are start and stop
            if (bit_cnt_q >= 5'd1 && bit_cnt_q <= 5'd14) begin
              shift_q <= {din, shift_q[`PMEA_WORD_W-1:1]};
            end
            bit_cnt_q <= data_done ? 5'd0 : bit_cnt_q + 5'd1;
            if (data_done) begin
              state_q <= pmea_pkg::PMEA_ST_CMD;
            end
          end
        end
        default: begin
          state_q <= pmea_pkg::PMEA_ST_CMD;
          bit_cnt_q <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // read data out on rising edges
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_data_pin_out <= 1'b0;
      prog_data_pin_oe <= 1'b0;
    // release with the synchronised level, so the pin never outlives the mode
    end else if (!hv_sync_q[1] || state_q != pmea_pkg::PMEA_ST_DATA || !is_read_q
        || data_done) begin
      prog_data_pin_out <= 1'b0;
      prog_data_pin_oe <= 1'b0;
    end else if (clk_rise) begin
      prog_data_pin_oe <= 1'b1;
      if (bit_cnt_q >= 5'd1 && bit_cnt_q <= 5'd14) begin
        prog_data_pin_out <= rd_word_q[4'(bit_cnt_q - 5'd1)];
      end else begin
        prog_data_pin_out <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // address counter and data latch
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= `PMEA_USER_BASE;
      latch_q <= `PMEA_ERASED;
    end else if (!mode_q || mode_entry) begin
      addr_q <= `PMEA_USER_BASE;
      latch_q <= `PMEA_ERASED;
    end else if (cmd_done && op == `PMEA_CMD_INCR) begin
      addr_q <= next_addr(addr_q);
    end else if (data_done && !is_read_q) begin
      latch_q <= shift_q;
      if (is_cfg_load_q) begin
        addr_q <= `PMEA_CFG_BASE;
      end
    end
  end

  assign array_rd_addr = addr_q;

  // ----------------------------------------
  // configuration words
  // ----------------------------------------
  logic do_begin;
  logic do_bulk;

  assign do_begin = cmd_done && (op == `PMEA_CMD_BEGIN);
  assign do_bulk = cmd_done && (op == `PMEA_CMD_BULK_PROG);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `PMEA_CFG_WORDS; i++) begin
        cfg_q[i] <= `PMEA_ERASED;
      end
      cfg_q[`PMEA_IDX_CAL0] <= `PMEA_CAL0_RST;
      cfg_q[`PMEA_IDX_CAL1] <= `PMEA_CAL1_RST;
    end else if (do_begin && in_cfg && cfg_usable(addr_q, alt_group_q)) begin
      cfg_q[cfg_idx] <= latch_q;
    end else if (do_bulk) begin
      // calibration words are never touched by a bulk erase
      cfg_q[`PMEA_IDX_CONFIG] <= `PMEA_ERASED;
      if (in_cfg) begin
        for (int i = 0; i <= 3; i++) begin
          cfg_q[i] <= `PMEA_ERASED;
        end
      end
    end
  end

  // ----------------------------------------
  // writes to the program array through the buffer
  // ----------------------------------------
  logic pend_q;
  logic fifo_ready;
  pmea_pkg::pmea_wr_t pend_word_q;
  pmea_pkg::pmea_wr_t fifo_out;

  // the programmer cannot be stalled, so a full buffer holds one word here
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 1'b0;
      pend_word_q <= '0;
    end else if (do_begin && !in_cfg && !pend_q) begin
      pend_q <= 1'b1;
      pend_word_q <= '{addr: addr_q, data: latch_q};
    end else if (pend_q && fifo_ready) begin
      pend_q <= 1'b0;
    end
  end

  pmea_fifo #(
    .WIDTH($bits(pmea_pkg::pmea_wr_t)),
    .DEPTH(`PMEA_FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(pend_q),
    .in_ready(fifo_ready),
    .in_data(pend_word_q),
    .out_valid(array_wr_valid),
    .out_ready(array_wr_ready),
    .out_data(fifo_out)
  );

  assign array_wr_word = fifo_out;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      array_erase <= 1'b0;
    end else begin
      array_erase <= do_bulk;
    end
  end
endmodule

// file: test/pmea_prog_if_assertions.sv
// concurrent checks on the ports of the program/verify mode block
// assumes one core_clk domain and a bind onto pmea_prog_if
`include "pmea_cfg.svh"

module pmea_prog_if_assertions (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // pins and mode
  input wire logic master_clear_hv,
  input wire logic prog_data_pin_oe,
  input wire logic prog_mode_active,
  input wire logic other_logic_reset,
  input wire logic port_a_bit_four_hiz,
  // array side
  input wire logic [`PMEA_ADDR_W-1:0] array_rd_addr,
  input wire logic array_wr_valid,
  input wire logic array_wr_ready,
  input wire pmea_pkg::pmea_wr_t array_wr_word,
  input wire logic array_erase
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  logic mode_q;
  logic [`PMEA_ADDR_W-1:0] addr_q;
  logic stay;

  // previous counter, to judge every change against its cause
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= 1'b0;
      addr_q <= 14'h0000;
    end else begin
      mode_q <= prog_mode_active;
      addr_q <= array_rd_addr;
    end
  end
  assign stay = prog_mode_active && mode_q;

  step_user_a:
  assert property (stay && !addr_q[13] && array_rd_addr != addr_q |->
    array_rd_addr == {1'b0, addr_q[12:0] + 13'h1} || array_rd_addr == `PMEA_CFG_BASE)
    else $error("user counter step wrong");
  step_cfg_a:
  assert property (stay && addr_q[13] && array_rd_addr != addr_q |->
    array_rd_addr == {1'b1, addr_q[12:0] + 13'h1} || array_rd_addr == `PMEA_CFG_BASE)
    else $error("config counter step wrong");
  cfg_sticky_a:
  assert property (stay && addr_q[13] |-> array_rd_addr[13])
    else $error("counter left config region");
  entry_clear_a:
  assert property ($rose(prog_mode_active) |-> array_rd_addr == 14'h0000 && !prog_data_pin_oe)
    else $error("entry did not clear counter");
  mode_outs_a:
  assert property (other_logic_reset == prog_mode_active && port_a_bit_four_hiz == prog_mode_active)
    else $error("mode outputs disagree");
  hv_entry_a:
  assert property ($rose(master_clear_hv) |-> ##[1:4] prog_mode_active)
    else $error("mode not entered");
  hv_exit_a:
  assert property (!master_clear_hv [*5] |-> !prog_mode_active)
    else $error("mode held without high voltage");
  drive_mode_a:
  assert property (prog_data_pin_oe |-> prog_mode_active)
    else $error("data pin driven outside mode");
  erase_pulse_a:
  assert property (array_erase |=> !array_erase)
    else $error("erase pulse too long");
  wr_hold_a:
  assert property (array_wr_valid && !array_wr_ready |=> array_wr_valid && $stable(array_wr_word))
    else $error("write word dropped while stalled");

  cover property ($rose(prog_mode_active));
  cover property (prog_data_pin_oe && array_rd_addr[13]);
  cover property (array_wr_valid && !array_wr_ready);
  cover property (array_erase);
endmodule

bind pmea_prog_if pmea_prog_if_assertions chk (
  .core_clk(core_clk), .rst_n(rst_n), .master_clear_hv(master_clear_hv),
  .prog_data_pin_oe(prog_data_pin_oe), .prog_mode_active(prog_mode_active),
  .other_logic_reset(other_logic_reset), .port_a_bit_four_hiz(port_a_bit_four_hiz),
  .array_rd_addr(array_rd_addr), .array_wr_valid(array_wr_valid),
  .array_wr_ready(array_wr_ready), .array_wr_word(array_wr_word), .array_erase(array_erase)
);

// file: test/pmea_programmer_model.sv
// serial programmer model: pin clock, data line and high voltage
// assumes the bench resolves the data wire from both drivers
module pmea_programmer_model (
  // clock of the bench
  input wire logic core_clk,
  // resolved data line
  input wire logic data_wire,
  // pins driven
  output logic clk_pin,
  output logic data_drv,
  output logic hv
);
  timeunit 1ns;
  timeprecision 1ps;
  logic vdd;

  initial begin
    vdd = 1'b0;
    clk_pin = 1'b0;
    data_drv = 1'b0;
    hv = 1'b0;
  end

  task automatic enter();
    clk_pin <= 1'b0;
    data_drv <= 1'b0;
    @(posedge core_clk);
    // high voltage before supply, so stored code never gets to run
    hv <= 1'b1;
    @(posedge core_clk);
    vdd <= 1'b1;
    repeat (8) @(posedge core_clk);
  endtask

  // the only way back to user memory is to leave and enter again
  task automatic leave();
    vdd <= 1'b0;
    @(posedge core_clk);
    hv <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask

  // one 160 ns pin clock; a released line toggles so stale data never passes
  task automatic cyc(input logic b, input logic rel, output logic s);
    clk_pin <= 1'b1;
    data_drv <= rel ? ~data_drv : b;
    repeat (4) @(posedge core_clk);
    clk_pin <= 1'b0;
    repeat (4) @(posedge core_clk);
    s = data_wire;
  endtask

  task automatic cmd(input logic [5:0] c);
    logic s;
    for (int i = 0; i < 6; i++) cyc(c[i], 1'b0, s);
    repeat (8) @(posedge core_clk);
  endtask

  task automatic word(input logic [13:0] w, input logic rel, output logic [13:0] r);
    logic [15:0] f;
    logic s;
    f = {1'b0, w, 1'b0};
    r = 14'h0000;
    for (int i = 0; i < 16; i++) begin
      cyc(f[i], rel, s);
      if (i > 0 && i < 15) r = {s, r[13:1]};
    end
    repeat (8) @(posedge core_clk);
  endtask
endmodule

// file: test/testbench.sv
// self-checking bench for the program/verify mode block
// assumes the programmer model on the pins and a stalling array sink
`include "pmea_cfg.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic code_protect = 1'b0;
  logic array_wr_ready = 1'b0;
  logic alt_strap = 1'b0;
  logic clk_pin, data_drv, hv, data_wire, oe, dout, mode, hiz, erase, wr_valid, other_rst;
  logic [13:0] addr, rd_data, r;
  pmea_pkg::pmea_wr_t wr_word;
  pmea_pkg::pmea_wr_t got[$];
  int err_total = 0;
  int total_checks = 0;
  int erase_seen = 0;

  always #10 core_clk = ~core_clk;
  assign data_wire = oe ? dout : data_drv;
  // array contents follow the address so every read is predictable
  assign rd_data = addr ^ 14'h1a5c;

  pmea_prog_if dut (
    .core_clk(core_clk), .rst_n(rst_n), .prog_clock_pin(clk_pin),
    .prog_data_pin_in(data_wire), .prog_data_pin_out(dout), .prog_data_pin_oe(oe),
    .master_clear_hv(hv), .alt_group_strap(alt_strap), .code_protect(code_protect),
    .prog_mode_active(mode), .other_logic_reset(other_rst), .port_a_bit_four_hiz(hiz),
    .array_rd_addr(addr), .array_rd_data(rd_data), .array_wr_valid(wr_valid),
    .array_wr_ready(array_wr_ready), .array_wr_word(wr_word), .array_erase(erase)
  );
  pmea_programmer_model host (
    .core_clk(core_clk), .data_wire(data_wire), .clk_pin(clk_pin),
    .data_drv(data_drv), .hv(hv)
  );

  always @(posedge core_clk) begin
    if (wr_valid && array_wr_ready) got.push_back(wr_word);
    if (erase) erase_seen++;
  end

  task automatic ld(input logic [3:0] c, input logic [13:0] w);
    logic [13:0] s;
    host.cmd({2'b00, c});
    host.word(w, 1'b0, s);
  endtask
  task automatic rd(output logic [13:0] v);
    host.cmd({2'b00, `PMEA_CMD_READ_PROG});
    host.word(14'h0000, 1'b1, v);
  endtask
  task automatic op(input logic [3:0] c, input int n);
    for (int i = 0; i < n; i++) host.cmd({2'b00, c});
  endtask

  task automatic t_entry();
    host.enter();
    `CHK(mode, 1'b1)
    `CHK(hiz, 1'b1)
    `CHK(other_rst, 1'b1)
    `CHK(addr, 14'h0000)
  endtask

  task automatic t_user_read();
    op(`PMEA_CMD_INCR, 3);
    `CHK(addr, 14'h0003)
    rd(r);
    `CHK(r, 14'h0003 ^ 14'h1a5c)
    code_protect <= 1'b1;
    rd(r);
    `CHK(r, 14'h0000)
  endtask

  task automatic t_config();
    ld(`PMEA_CMD_LOAD_CFG, 14'h3abc);
    `CHK(addr, `PMEA_CFG_BASE)
    op(`PMEA_CMD_BEGIN, 1);
    rd(r);
    `CHK(r, 14'h3abc)
    op(`PMEA_CMD_INCR, 4);
    rd(r);
    `CHK(r, 14'h0000)
    op(`PMEA_CMD_INCR, 4);
    rd(r);
    `CHK(r, `PMEA_CAL0_RST)
    ld(`PMEA_CMD_LOAD_PROG, 14'h0123);
    op(`PMEA_CMD_BEGIN, 1);
    op(`PMEA_CMD_BULK_PROG, 1);
    rd(r);
    `CHK(r, 14'h0123)
    op(`PMEA_CMD_INCR, 1);
    rd(r);
    `CHK(r, 14'h0000)
    ld(`PMEA_CMD_LOAD_CFG, 14'h0000);
    rd(r);
    `CHK(r, `PMEA_ERASED)
    code_protect <= 1'b0;
  endtask

  // sink stalls until the buffer and its pending word are full
  task automatic t_fifo();
    host.leave();
    `CHK(mode, 1'b0)
    `CHK(other_rst, 1'b0)
    host.enter();
    `CHK(addr, 14'h0000)
    for (int i = 0; i < 9; i++) begin
      ld(`PMEA_CMD_LOAD_PROG, 14'h0100 + 14'(i));
      op(`PMEA_CMD_BEGIN, 1);
      op(`PMEA_CMD_INCR, 1);
    end
    `CHK(wr_valid, 1'b1)
    `CHK(got.size(), 0)
    array_wr_ready <= 1'b1;
    for (int k = 0; k < 50 && wr_valid !== 1'b0; k++) @(posedge core_clk);
    `CHK(wr_valid, 1'b0)
    `CHK(got.size(), 9)
    foreach (got[i]) `CHK(got[i], {14'(i), 14'h0100 + 14'(i)})
    erase_seen = 0;
    op(`PMEA_CMD_BULK_PROG, 1);
    repeat (8) @(posedge core_clk);
    `CHK(erase_seen, 1)
  endtask

  // alternate group: strap is only taken after a fresh reset
  task automatic t_alt();
    host.leave();
    alt_strap <= 1'b1;
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    host.enter();
    ld(`PMEA_CMD_LOAD_CFG, 14'h0000);
    op(`PMEA_CMD_INCR, 6);
    rd(r);
    `CHK(r, `PMEA_ERASED)
    op(`PMEA_CMD_INCR, 3);
    rd(r);
    `CHK(r, `PMEA_CAL1_RST)
    op(`PMEA_CMD_INCR, 1);
    rd(r);
    `CHK(r, 14'h0000)
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    t_entry();
    t_user_read();
    t_config();
    t_fifo();
    t_alt();
    tally_and_finish();
  end

  // the scenarios need about 7000 cycles
  initial begin
    repeat (80000) @(posedge core_clk);
    err_total++;
    tally_and_finish();
  end
endmodule
